// ---- verilog/tts_pkg.sv ----
/*
 Shared constants, register map and carrier types of the trace trigger sequencer.
 Assumes a 32-bit captured bus state and word-aligned AHB-Lite register access.
*/
// How it works
// [R1] every term owns its primary qualifier
// [R2] one secondary qualifier restarts to term one
// [R3] primary match advances exactly one term
// [R4] secondary match from any term restarts
// [R5] branch out of last term triggers
// [R6] one to four terms, refuse beyond
// [R7] insert shifts existing terms up, else appends
// [R8] delete renumbers terms contiguously from one
// [R9] branch states always stored in trace memory
// [R10] stored states flag branch condition
// [R11] after trigger fill memory then stop
// [R12] trigger position selectable, centre included
// [R13] complex select reinitialises everything to defaults; sel_r, mem_idx_r and the trace memory are kept
// [R14] occurrence count gates the primary branch
// [R15] reset gives single any term, restart never
// [R16] one global storage qualifier for all terms
// [R17] one state per capture, primary wins
// [R18] term index and occurrences readable status
package tts_pkg;

	localparam int CAP_W     = 32;
	localparam int OCC_W     = 16;
	localparam int MAX_TERMS = 4;

	typedef struct packed {
		logic             en;
		logic [CAP_W-1:0] value;
		logic [CAP_W-1:0] mask;
	} tts_qual_t;

	typedef struct packed {
		tts_qual_t        qual;
		logic [OCC_W-1:0] occ;
	} tts_term_t;

	typedef struct packed {
		logic [CAP_W-1:0] state;
		logic             branch;
		logic             trig;
	} tts_entry_t;

	typedef enum logic [1:0] {
		TTS_TP_START,
		TTS_TP_CENTER,
		TTS_TP_END
	} tts_tpos_t;

	// mask bit set means the bit is ignored; en low means "never"
	localparam tts_qual_t QUAL_ANY   = '{en: 1'b1, value: 32'h0000_0000, mask: 32'hFFFF_FFFF};
	localparam tts_qual_t QUAL_NEVER = '{en: 1'b0, value: 32'h0000_0000, mask: 32'h0000_0000};
	localparam tts_term_t TERM_ANY   = '{qual: QUAL_ANY, occ: 16'h0001};

	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_CMD       = 8'h04;
	localparam logic [7:0] ADDR_TERM_SEL  = 8'h08;
	localparam logic [7:0] ADDR_TERM_VAL  = 8'h0C;
	localparam logic [7:0] ADDR_TERM_MASK = 8'h10;
	localparam logic [7:0] ADDR_TERM_CFG  = 8'h14;
	localparam logic [7:0] ADDR_RST_VAL   = 8'h18;
	localparam logic [7:0] ADDR_RST_MASK  = 8'h1C;
	localparam logic [7:0] ADDR_RST_CFG   = 8'h20;
	localparam logic [7:0] ADDR_STO_VAL   = 8'h24;
	localparam logic [7:0] ADDR_STO_MASK  = 8'h28;
	localparam logic [7:0] ADDR_STO_CFG   = 8'h2C;
	localparam logic [7:0] ADDR_STATUS    = 8'h30;
	localparam logic [7:0] ADDR_MEM_CNT   = 8'h34;
	localparam logic [7:0] ADDR_MEM_IDX   = 8'h38;
	localparam logic [7:0] ADDR_MEM_DATA  = 8'h3C;
	localparam logic [7:0] ADDR_MEM_FLAG  = 8'h40;

	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT  = 1;
	localparam int CTRL_SQRST_BIT = 2;
	localparam int CTRL_CPLX_BIT  = 3;
	localparam int CTRL_TP_LSB    = 4;
	localparam int CMD_INS_BIT    = 8;
	localparam int CMD_DEL_BIT    = 9;
	localparam int CFG_EN_BIT     = 0;
	localparam int CFG_OCC_LSB    = 16;
	localparam int ST_IDX_LSB     = 4;
	localparam int ST_CNT_LSB     = 8;
	localparam int ST_OCC_LSB     = 16;

endpackage : tts_pkg

// ---- verilog/tts_trace_mem.sv ----
/*
 Circular trace memory of flip-flops holding captured states with branch flags.
 Assumes one write pulse per stored state and a reader that indexes oldest-first.
*/
`timescale 1ns/10ps
module tts_trace_mem #(
	parameter int DEPTH = 16
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       clear_i,
	input  wire logic                       wr_i,
	input  wire tts_pkg::tts_entry_t        wr_data_i,
	input  wire logic [$clog2(DEPTH)-1:0]   rd_idx_i,
	output tts_pkg::tts_entry_t             rd_data_o,
	output logic      [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_chk
			$error("trace depth must be a power of two, at least 2");
		end
	endgenerate

	tts_pkg::tts_entry_t mem_r [DEPTH];
	logic [AW-1:0]       wptr_r;
	logic [AW-1:0]       rd_addr;

	always_ff @(posedge clk_i)
	begin
		if (wr_i)
			mem_r[wptr_r] <= wr_data_i;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			wptr_r <= '0;
		else if (clear_i)
			wptr_r <= '0;
		else if (wr_i)
			wptr_r <= wptr_r + AW'(1);
	end

	// oldest entries are overwritten while waiting for the trigger
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			count_o <= '0;
		else if (clear_i)
			count_o <= '0;
		else if (wr_i && count_o != CW'(DEPTH))
			count_o <= count_o + CW'(1);
	end

	assign rd_addr   = wptr_r - count_o[AW-1:0] + rd_idx_i;
	assign rd_data_o = mem_r[rd_addr];

endmodule : tts_trace_mem

// ---- verilog/tts_top.sv ----
/*
 Trace trigger sequencer with AHB-Lite register slave and trace memory.
 Assumes one captured bus state per cap_valid_i pulse, synchronous to clk_i.
*/
`timescale 1ns/10ps
module tts_top #(
	parameter int DEPTH = 16
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     hsel_i,
	input  wire logic [31:0]              haddr_i,
	input  wire logic [1:0]               htrans_i,
	input  wire logic                     hwrite_i,
	input  wire logic [2:0]               hsize_i,
	input  wire logic                     hready_i,
	input  wire logic [31:0]              hwdata_i,
	output logic      [31:0]              hrdata_o,
	output logic                          hreadyout_o,
	output logic                          hresp_o,
	input  wire logic                     cap_valid_i,
	input  wire logic [tts_pkg::CAP_W-1:0] cap_state_i,
	output logic                          trigger_o,
	output logic                          running_o,
	output logic                          complete_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	localparam int OW = tts_pkg::OCC_W;

	generate
		if (tts_pkg::MAX_TERMS != 4)
		begin : g_chk
			$error("term logic is sized for four terms");
		end
	endgenerate

	typedef enum logic [1:0] {
		S_IDLE,
		S_RUN,
		S_FILL,
		S_DONE
	} tts_state_t;

	tts_state_t          state_r;
	tts_pkg::tts_term_t  terms_r [4];
	tts_pkg::tts_term_t  ins_t   [4];
	tts_pkg::tts_term_t  del_t   [4];
	tts_pkg::tts_qual_t  rst_q_r;
	tts_pkg::tts_qual_t  sto_q_r;
	logic [2:0]          term_cnt_r;
	logic [1:0]          sel_r;
	tts_pkg::tts_tpos_t  tpos_r;
	logic                complex_r;
	logic                refused_r;
	logic [2:0]          idx_r;
	logic [OW-1:0]       occ_r;
	logic [AW-1:0]       post_r;
	logic [AW-1:0]       post_len;
	logic [AW-1:0]       mem_idx_r;
	logic [CW-1:0]       mem_cnt;
	tts_pkg::tts_entry_t mem_rd;
	tts_pkg::tts_entry_t mem_wd;
	logic                mem_wr;

	// bus phase capture
	logic        dp_wr_r;
	logic [7:0]  dp_addr_r;
	logic        addr_ok;
	logic        wr_en;
	logic [31:0] rd_val;

	assign addr_ok     = hsel_i && hready_i && htrans_i[1];
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dp_wr_r   <= 1'b0;
			dp_addr_r <= 8'h00;
		end
		else
		begin
			dp_wr_r   <= addr_ok && hwrite_i;
			dp_addr_r <= haddr_i[7:0];
		end
	end

	assign wr_en = dp_wr_r;

	// control strobes, all one-cycle pulses from a CTRL or CMD write
	logic       wr_ctrl;
	logic       wr_cmd;
	logic       start_p;
	logic       stop_p;
	logic       sqrst_p;
	logic       init_p;
	logic       busy;
	logic [2:0] cmd_k;
	logic       ins_p;
	logic       del_p;
	logic       ins_ok;
	logic       del_ok;
	logic [2:0] pos;

	assign wr_ctrl = wr_en && dp_addr_r == tts_pkg::ADDR_CTRL;
	assign wr_cmd  = wr_en && dp_addr_r == tts_pkg::ADDR_CMD;
	assign start_p = wr_ctrl && hwdata_i[tts_pkg::CTRL_START_BIT];
	assign stop_p  = wr_ctrl && hwdata_i[tts_pkg::CTRL_STOP_BIT];
	assign sqrst_p = wr_ctrl && hwdata_i[tts_pkg::CTRL_SQRST_BIT];
	// entering complex, or leaving it, reloads every default but sel_r, mem_idx_r and the trace memory; a control write
	// that keeps the mode must still be able to start a run in complex mode
	assign init_p  = wr_ctrl && (hwdata_i[tts_pkg::CTRL_CPLX_BIT]
		!= complex_r); // [R13]
	assign busy    = state_r == S_RUN || state_r == S_FILL;
	assign cmd_k   = hwdata_i[2:0];
	assign ins_p   = wr_cmd && hwdata_i[tts_pkg::CMD_INS_BIT];
	assign del_p   = wr_cmd && hwdata_i[tts_pkg::CMD_DEL_BIT] && !ins_p;
	assign ins_ok  = ins_p && !busy && cmd_k != 3'h0 && term_cnt_r < 3'h4; // [R6]
	assign del_ok  = del_p && !busy && cmd_k != 3'h0 && cmd_k <= term_cnt_r
		&& term_cnt_r != 3'h1; // [R6]
	// an index past the end appends instead of inserting
	assign pos     = (ins_p && cmd_k > term_cnt_r) ? term_cnt_r : cmd_k - 3'h1; // [R7]

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_term
			if (gi == 0)
			begin : g_lo
				assign ins_t[gi] = (pos == 3'h0) ? tts_pkg::TERM_ANY : terms_r[gi];
			end
			else
			begin : g_hi
				assign ins_t[gi] = (3'(gi) > pos) ? terms_r[gi-1] :
					(3'(gi) == pos) ? tts_pkg::TERM_ANY : terms_r[gi]; // [R7]
			end
			if (gi == 3)
			begin : g_top
				assign del_t[gi] = (3'(gi) >= pos) ? tts_pkg::TERM_ANY : terms_r[gi];
			end
			else
			begin : g_mid
				assign del_t[gi] = (3'(gi) >= pos) ? terms_r[gi+1] : terms_r[gi]; // [R8]
			end
		end
	endgenerate

	// term table: defaults, insert/delete, and the selected-term window
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 4; i++)
				terms_r[i] <= tts_pkg::TERM_ANY;
			term_cnt_r <= 3'h1;
		end
		else if (init_p || sqrst_p)
		begin
			for (int i = 0; i < 4; i++)
				terms_r[i] <= tts_pkg::TERM_ANY; // [R15]
			term_cnt_r <= 3'h1;
		end
		else if (ins_ok)
		begin
			for (int i = 0; i < 4; i++)
				terms_r[i] <= ins_t[i];
			term_cnt_r <= term_cnt_r + 3'h1;
		end
		else if (del_ok)
		begin
			for (int i = 0; i < 4; i++)
				terms_r[i] <= del_t[i];
			term_cnt_r <= term_cnt_r - 3'h1;
		end
		else if (wr_en && !busy)
		begin
			if (dp_addr_r == tts_pkg::ADDR_TERM_VAL)
				terms_r[sel_r].qual.value <= hwdata_i; // [R1]
			else if (dp_addr_r == tts_pkg::ADDR_TERM_MASK)
				terms_r[sel_r].qual.mask <= hwdata_i;
			else if (dp_addr_r == tts_pkg::ADDR_TERM_CFG)
			begin
				terms_r[sel_r].qual.en <= hwdata_i[tts_pkg::CFG_EN_BIT];
				terms_r[sel_r].occ     <= hwdata_i[tts_pkg::CFG_OCC_LSB +: OW]; // [R14]
			end
		end
	end

	// global restart and storage qualifiers
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rst_q_r <= tts_pkg::QUAL_NEVER;
			sto_q_r <= tts_pkg::QUAL_ANY;
		end
		else if (init_p || sqrst_p)
		begin
			rst_q_r <= tts_pkg::QUAL_NEVER; // [R15]
			sto_q_r <= tts_pkg::QUAL_ANY;
		end
		else if (wr_en && !busy)
		begin
			if (dp_addr_r == tts_pkg::ADDR_RST_VAL)
				rst_q_r.value <= hwdata_i; // [R2]
			else if (dp_addr_r == tts_pkg::ADDR_RST_MASK)
				rst_q_r.mask <= hwdata_i;
			else if (dp_addr_r == tts_pkg::ADDR_RST_CFG)
				rst_q_r.en <= hwdata_i[tts_pkg::CFG_EN_BIT];
			else if (dp_addr_r == tts_pkg::ADDR_STO_VAL)
				sto_q_r.value <= hwdata_i; // [R16]
			else if (dp_addr_r == tts_pkg::ADDR_STO_MASK)
				sto_q_r.mask <= hwdata_i;
			else if (dp_addr_r == tts_pkg::ADDR_STO_CFG)
				sto_q_r.en <= hwdata_i[tts_pkg::CFG_EN_BIT];
		end
	end

	// configuration: selection window, trigger position, mode
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sel_r     <= 2'h0;
			tpos_r    <= tts_pkg::TTS_TP_START;
			complex_r <= 1'b0;
			mem_idx_r <= '0;
		end
		else
		begin
			if (init_p)
			begin
				complex_r <= hwdata_i[tts_pkg::CTRL_CPLX_BIT];
				tpos_r    <= tts_pkg::TTS_TP_START; // [R13]
			end
			else if (wr_ctrl && !busy && hwdata_i[tts_pkg::CTRL_TP_LSB +: 2] != 2'h3)
				tpos_r <= tts_pkg::tts_tpos_t'(hwdata_i[tts_pkg::CTRL_TP_LSB +: 2]); // [R12]
			if (wr_en && dp_addr_r == tts_pkg::ADDR_TERM_SEL)
				sel_r <= hwdata_i[1:0];
			if (wr_en && dp_addr_r == tts_pkg::ADDR_MEM_IDX)
				mem_idx_r <= hwdata_i[AW-1:0];
		end
	end

	// last command outcome; a later accepted command clears it
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			refused_r <= 1'b0;
		else if (init_p)
			refused_r <= 1'b0;
		else if (ins_p || del_p)
			refused_r <= !(ins_ok || del_ok); // [R6]
	end

	// qualifier evaluation on the present captured state
	function automatic logic qmatch(input tts_pkg::tts_qual_t q,
		input logic [tts_pkg::CAP_W-1:0] s);
		qmatch = q.en && (((s ^ q.value) & ~q.mask) == '0);
	endfunction : qmatch

	function automatic logic [OW-1:0] occ_load(input logic [OW-1:0] n);
		occ_load = (n == '0) ? OW'(1) : n;
	endfunction : occ_load

	logic pri_hit;
	logic sec_hit;
	logic sto_hit;
	logic pri_br;
	logic sec_br;
	logic last_term;
	logic trig_ev;

	assign pri_hit   = qmatch(terms_r[idx_r[1:0]].qual, cap_state_i); // [R1]
	assign sec_hit   = qmatch(rst_q_r, cap_state_i); // [R2]
	assign sto_hit   = qmatch(sto_q_r, cap_state_i); // [R16]
	assign last_term = idx_r == term_cnt_r - 3'h1;
	// the primary branch is taken only on the final counted occurrence
	assign pri_br    = state_r == S_RUN && cap_valid_i && pri_hit
		&& occ_r == OW'(1); // [R14] [R17]
	// a counting primary match still leaves the restart free to act
	assign sec_br    = state_r == S_RUN && cap_valid_i && sec_hit && !pri_br; // [R4] [R17]
	assign trig_ev   = pri_br && last_term; // [R5]

	always_comb
	begin
		case (tpos_r)
			tts_pkg::TTS_TP_CENTER: post_len = AW'(DEPTH / 2); // [R12]
			tts_pkg::TTS_TP_END:    post_len = '0;
			default:                post_len = AW'(DEPTH - 1);
		endcase
	end

	// sequencer
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r <= S_IDLE;
			idx_r   <= 3'h0;
			occ_r   <= OW'(1);
			post_r  <= '0;
		end
		else if (init_p || sqrst_p || stop_p)
		begin
			state_r <= S_IDLE;
			idx_r   <= 3'h0;
			occ_r   <= OW'(1);
		end
		else if (start_p)
		begin
			state_r <= S_RUN;
			idx_r   <= 3'h0;
			occ_r   <= occ_load(terms_r[0].occ);
		end
		else
		begin
			case (state_r)
				S_RUN:
				begin
					if (trig_ev)
					begin
						idx_r   <= term_cnt_r; // [R18]
						post_r  <= post_len;
						state_r <= (post_len == '0) ? S_DONE : S_FILL; // [R11]
					end
					else if (pri_br)
					begin
						idx_r <= idx_r + 3'h1; // [R3]
						occ_r <= occ_load(terms_r[idx_r[1:0] + 2'h1].occ);
					end
					else if (sec_br)
					begin
						idx_r <= 3'h0; // [R4]
						occ_r <= occ_load(terms_r[0].occ);
					end
					else if (cap_valid_i && pri_hit)
						occ_r <= occ_r - OW'(1); // [R14]
				end
				S_FILL:
				begin
					if (cap_valid_i && sto_hit)
					begin
						post_r <= post_r - AW'(1);
						if (post_r == AW'(1))
							state_r <= S_DONE; // [R11]
					end
				end
				default:
				begin
					state_r <= state_r;
				end
			endcase
		end
	end

	// branch states bypass the storage qualifier
	assign mem_wr = cap_valid_i && ((state_r == S_RUN && (sto_hit || pri_br || sec_br))
		|| (state_r == S_FILL && sto_hit)); // [R9] [R11]
	assign mem_wd = '{state: cap_state_i, branch: pri_br || sec_br, trig: trig_ev}; // [R10]

	tts_trace_mem #(
		.DEPTH(DEPTH)
	) u_mem (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clear_i  (start_p),
		.wr_i     (mem_wr),
		.wr_data_i(mem_wd),
		.rd_idx_i (mem_idx_r),
		.rd_data_o(mem_rd),
		.count_o  (mem_cnt)
	);

	// read mux, sampled in the address phase so data stand for the data phase
	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (haddr_i[7:0] == tts_pkg::ADDR_CTRL)
		begin
			rd_val[tts_pkg::CTRL_CPLX_BIT]        = complex_r;
			rd_val[tts_pkg::CTRL_TP_LSB +: 2]     = tpos_r;
		end
		else if (haddr_i[7:0] == tts_pkg::ADDR_TERM_SEL)
			rd_val[1:0] = sel_r;
		else if (haddr_i[7:0] == tts_pkg::ADDR_TERM_VAL)
			rd_val = terms_r[sel_r].qual.value;
		else if (haddr_i[7:0] == tts_pkg::ADDR_TERM_MASK)
			rd_val = terms_r[sel_r].qual.mask;
		else if (haddr_i[7:0] == tts_pkg::ADDR_TERM_CFG)
		begin
			rd_val[tts_pkg::CFG_EN_BIT]           = terms_r[sel_r].qual.en;
			rd_val[tts_pkg::CFG_OCC_LSB +: OW]    = terms_r[sel_r].occ;
		end
		else if (haddr_i[7:0] == tts_pkg::ADDR_RST_VAL)
			rd_val = rst_q_r.value;
		else if (haddr_i[7:0] == tts_pkg::ADDR_RST_MASK)
			rd_val = rst_q_r.mask;
		else if (haddr_i[7:0] == tts_pkg::ADDR_RST_CFG)
			rd_val[tts_pkg::CFG_EN_BIT] = rst_q_r.en;
		else if (haddr_i[7:0] == tts_pkg::ADDR_STO_VAL)
			rd_val = sto_q_r.value;
		else if (haddr_i[7:0] == tts_pkg::ADDR_STO_MASK)
			rd_val = sto_q_r.mask;
		else if (haddr_i[7:0] == tts_pkg::ADDR_STO_CFG)
			rd_val[tts_pkg::CFG_EN_BIT] = sto_q_r.en;
		else if (haddr_i[7:0] == tts_pkg::ADDR_STATUS)
		begin
			rd_val[0]                          = busy;
			rd_val[1]                          = state_r == S_FILL || state_r == S_DONE;
			rd_val[2]                          = state_r == S_DONE;
			rd_val[3]                          = refused_r;
			rd_val[tts_pkg::ST_IDX_LSB +: 3]   = idx_r + 3'h1; // [R18]
			rd_val[tts_pkg::ST_CNT_LSB +: 3]   = term_cnt_r;
			rd_val[tts_pkg::ST_OCC_LSB +: OW]  = occ_r; // [R18]
		end
		else if (haddr_i[7:0] == tts_pkg::ADDR_MEM_CNT)
			rd_val[CW-1:0] = mem_cnt;
		else if (haddr_i[7:0] == tts_pkg::ADDR_MEM_IDX)
			rd_val[AW-1:0] = mem_idx_r;
		else if (haddr_i[7:0] == tts_pkg::ADDR_MEM_DATA)
			rd_val = mem_rd.state;
		else if (haddr_i[7:0] == tts_pkg::ADDR_MEM_FLAG)
			rd_val[1:0] = {mem_rd.trig, mem_rd.branch}; // [R10]
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			hrdata_o <= 32'h0000_0000;
		else if (addr_ok && !hwrite_i)
			hrdata_o <= rd_val;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			trigger_o <= 1'b0;
		else
			trigger_o <= trig_ev && !(init_p || sqrst_p || stop_p || start_p); // [R5]
	end

	assign running_o  = busy;
	assign complete_o = state_r == S_DONE;

endmodule : tts_top

// ---- tb/tts_cap_src.sv ----
/*
 Capture-side model: presents captured bus states, one per pulse.
 Assumes calls start just after a rising edge of clk_i.
*/
`timescale 1ns/10ps
module tts_cap_src (
	input  wire logic                      clk_i,
	output logic                           cap_valid_o,
	output logic [tts_pkg::CAP_W-1:0]      cap_state_o
);
	initial
	begin
		cap_valid_o = 1'b0;
		cap_state_o = 32'h0000_0000;
	end
	// one state per pulse, a quiet cycle after it
	task send(input logic [tts_pkg::CAP_W-1:0] s);
		cap_valid_o <= 1'b1;
		cap_state_o <= s;
		@(posedge clk_i);
		cap_valid_o <= 1'b0;
		// stale value inverted so nothing leans on a held bus
		cap_state_o <= ~s;
		@(posedge clk_i);
	endtask : send
endmodule : tts_cap_src

// ---- tb/tts_chk.sv ----
/*
 Port-level assertions of the trace trigger sequencer.
 Assumes hready_i is tied to hreadyout_o.
*/
`timescale 1ns/10ps
module tts_chk #(
	parameter int DEPTH = 16
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        hsel_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic        hready_i,
	input  wire logic        hreadyout_o,
	input  wire logic        hresp_o,
	input  wire logic        cap_valid_i,
	input  wire logic        trigger_o,
	input  wire logic        running_o,
	input  wire logic        complete_o
);
	logic wr_a;
	assign wr_a = hsel_i && hready_i && htrans_i[1] && hwrite_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ready_high_a: assert property (hreadyout_o) else $error("hreadyout low");
	resp_okay_a: assert property (!hresp_o) else $error("hresp not okay");
	trig_pulse_a: assert property (trigger_o |=> !trigger_o) else $error("trigger too long");
	trig_cause_a: assert property (trigger_o |-> $past(cap_valid_i) && $past(running_o))
		else $error("trigger without capture");
	trig_fill_a: assert property (trigger_o |-> running_o || complete_o)
		else $error("trigger outside fill");
	done_idle_a: assert property (complete_o |-> !running_o) else $error("done while running");
	run_start_a: assert property ($rose(running_o) |-> $past(wr_a, 2))
		else $error("run without write");
	done_hold_a: assert property ($fell(complete_o) |-> $past(wr_a, 2))
		else $error("done dropped alone");
endmodule : tts_chk
bind tts_top tts_chk #(.DEPTH(DEPTH)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .cap_valid_i(cap_valid_i), .trigger_o(trigger_o),
	.running_o(running_o), .complete_o(complete_o));

// ---- tb/tb.sv ----
/*
 Self-checking bench of the trace trigger sequencer.
 Assumes zero-wait AHB-Lite slave and capture model tts_cap_src.
*/
`timescale 1ns/10ps
module tb;
	localparam int D = 8;
	logic        clk_i, rst_i, hsel, hwrite, cv, trg, run, cmp, hro, hrs;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, cs, q;
	int          fail_count, samples_checked, trig_n;
	tts_top #(.DEPTH(D)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hready_i(hro), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hro),
		.hresp_o(hrs), .cap_valid_i(cv), .cap_state_i(cs), .trigger_o(trg),
		.running_o(run), .complete_o(cmp));
	tts_cap_src i_src (.clk_i(clk_i), .cap_valid_o(cv), .cap_state_o(cs));
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// counted mid-cycle so a check at the next rising edge already sees it
	always @(negedge clk_i) if (trg === 1'b1) trig_n <= trig_n + 1;
	task tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= {24'h000000, a};
		n = 0;
		do begin @(posedge clk_i); n++; end while (hro !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge clk_i); n++; end while (hro !== 1'b1 && n < 100);
		q = hrdata;
		if (n >= 100)
		begin
			chk("bus wait", 32'h0000_0000, 32'h0000_0001);
			tally_and_finish();
		end
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(n, q & m, e);
	endtask : rd
	task term(input logic [1:0] s, input logic [31:0] v, input logic [15:0] o);
		wr(tts_pkg::ADDR_TERM_SEL, {30'h0, s});
		wr(tts_pkg::ADDR_TERM_VAL, v);
		wr(tts_pkg::ADDR_TERM_MASK, 32'h0000_0000);
		wr(tts_pkg::ADDR_TERM_CFG, {o, 16'h0001});
	endtask : term
	task mem(input logic [7:0] i, input logic [31:0] v, input logic [1:0] f);
		wr(tts_pkg::ADDR_MEM_IDX, {24'h0, i});
		rd("mem data", tts_pkg::ADDR_MEM_DATA, 32'hFFFF_FFFF, v);
		rd("mem flag", tts_pkg::ADDR_MEM_FLAG, 32'h0000_0003, {30'h0, f});
	endtask : mem
	task t_default;
		rd("status rst", tts_pkg::ADDR_STATUS, 32'h0000_07FF, 32'h0000_0110);
		rd("unmapped", 8'h80, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(tts_pkg::ADDR_CTRL, 32'h0000_0021);
		i_src.send(32'h5A5A_0001);
		chk("trig count", trig_n, 1);
		chk("done", cmp, 1'b1);
		rd("status trig", tts_pkg::ADDR_STATUS, 32'h0000_07FF, 32'h0000_0126);
		rd("mem count", tts_pkg::ADDR_MEM_CNT, 32'hFFFF_FFFF, 32'h1);
		mem(8'h0, 32'h5A5A_0001, 2'h3);
	endtask : t_default
	task t_sequence;
		term(2'h0, 32'h1111_0001, 16'h0001);
		wr(tts_pkg::ADDR_CMD, 32'h0000_0102);
		term(2'h1, 32'h2222_0002, 16'h0002);
		wr(tts_pkg::ADDR_RST_VAL, 32'h3333_0003);
		wr(tts_pkg::ADDR_RST_MASK, 32'h0000_0000);
		wr(tts_pkg::ADDR_RST_CFG, 32'h0000_0001);
		wr(tts_pkg::ADDR_STO_CFG, 32'h0000_0000);
		wr(tts_pkg::ADDR_CTRL, 32'h0000_0021);
		i_src.send(32'h2222_0002);
		i_src.send(32'h1111_0001);
		rd("term two", tts_pkg::ADDR_STATUS, 32'hFFFF_07F1, 32'h0002_0221);
		i_src.send(32'h2222_0002);
		rd("occ left", tts_pkg::ADDR_STATUS, 32'hFFFF_07F1, 32'h0001_0221);
		i_src.send(32'h3333_0003);
		rd("restart", tts_pkg::ADDR_STATUS, 32'h0000_07F1, 32'h0000_0211);
		i_src.send(32'h1111_0001);
		i_src.send(32'h2222_0002);
		chk("no trig yet", trig_n, 1);
		i_src.send(32'h2222_0002);
		chk("trig seq", trig_n, 2);
		rd("stored", tts_pkg::ADDR_MEM_CNT, 32'hFFFF_FFFF, 32'h4);
		mem(8'h1, 32'h3333_0003, 2'h1);
		mem(8'h3, 32'h2222_0002, 2'h3);
	endtask : t_sequence
	task t_edit;
		wr(tts_pkg::ADDR_CTRL, 32'h0000_0004);
		term(2'h0, 32'hABCD_0001, 16'h0001);
		for (int k = 2; k <= 4; k++) wr(tts_pkg::ADDR_CMD, 32'h0000_0100 | k);
		wr(tts_pkg::ADDR_CMD, 32'h0000_0102);
		rd("full", tts_pkg::ADDR_STATUS, 32'h0000_0708, 32'h0000_0408);
		wr(tts_pkg::ADDR_CMD, 32'h0000_0205);
		rd("del bad", tts_pkg::ADDR_STATUS, 32'h0000_0708, 32'h0000_0408);
		wr(tts_pkg::ADDR_CMD, 32'h0000_0202);
		rd("del ok", tts_pkg::ADDR_STATUS, 32'h0000_0708, 32'h0000_0300);
		wr(tts_pkg::ADDR_CMD, 32'h0000_0101);
		wr(tts_pkg::ADDR_TERM_SEL, 32'h1);
		rd("shifted", tts_pkg::ADDR_TERM_VAL, 32'hFFFF_FFFF, 32'hABCD_0001);
		wr(tts_pkg::ADDR_TERM_SEL, 32'h0);
		rd("new any", tts_pkg::ADDR_TERM_MASK, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
	endtask : t_edit
	task t_centre;
		wr(tts_pkg::ADDR_CTRL, 32'h0000_0004);
		term(2'h0, 32'h7777_0007, 16'h0001);
		wr(tts_pkg::ADDR_CTRL, 32'h0000_0011);
		for (int k = 0; k < 3; k++) i_src.send(32'h0000_0100 + k);
		i_src.send(32'h7777_0007);
		for (int k = 0; k < D / 2 - 1; k++) i_src.send(32'h0000_0200 + k);
		chk("still fill", cmp, 1'b0);
		i_src.send(32'h0000_0300);
		chk("filled", cmp, 1'b1);
		rd("centre cnt", tts_pkg::ADDR_MEM_CNT, 32'hFFFF_FFFF, D);
		mem(8'h3, 32'h7777_0007, 2'h3);
	endtask : t_centre
	task t_complex;
		wr(tts_pkg::ADDR_CMD, 32'h0000_0102);
		rd("two terms", tts_pkg::ADDR_STATUS, 32'h0000_0700, 32'h0000_0200);
		wr(tts_pkg::ADDR_CTRL, 32'h0000_0018);
		rd("cplx mode", tts_pkg::ADDR_CTRL, 32'h0000_0038, 32'h0000_0008);
		rd("cplx terms", tts_pkg::ADDR_STATUS, 32'h0000_07F7, 32'h0000_0110);
		wr(tts_pkg::ADDR_CTRL, 32'h0000_0000);
		rd("easy mode", tts_pkg::ADDR_CTRL, 32'h0000_0038, 32'h0000_0000);
	endtask : t_complex
	initial
	begin
		fail_count = 0;
		samples_checked = 0;
		trig_n = 0;
		rst_i = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		hwrite = 1'b0;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_default();
		t_sequence();
		t_edit();
		t_centre();
		t_complex();
		tally_and_finish();
	end
endmodule : tb
